/* design/qcpm_top.sv */
// two-channel quadrature counter with four-channel pulse width, period and frequency meter
//
// Behaviour
// - default mode counts exactly one per full quadrature cycle
// - x2 mode counts one per two phase edges
// - x4 mode counts on every edge of either phase
// - mode word is 16 bits; upper byte selects channel 1 or 2
// - mode word lower byte: 0 simple, 1 x1, 2 x2, 3 x4
// - mode word write overrides older simple/enhanced selection
// - four meters measure high width, period and frequency of their input
// - width and period reported in whole microseconds by default
// - frequency reported as integer hertz
// - resolution bit set gives width and period in tenths of microseconds
// - reported period is the inverse of reported frequency
// - one input feeds counting and measuring without mutual disturbance
// - meters measure accurately up to 10 kHz inputs
// - phase A leading counts up, lagging counts down
// - counter 1 uses inputs 0 and 1, counter 2 inputs 2 and 3
// - enabling a counter also enables metering of its two inputs
// - enabling metering on a counter input pair disables that counter
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
module qcpm_top #(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] in_sig,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("qcpm_top: CNT_W must lie between 2 and 32");
    end
  endgenerate

  // ==========================================================================
  // functions
  function automatic logic [1:0] quad_step(qcpm_pkg::qcpm_mode_t mode, logic pa, logic pb,
                                           logic a, logic b);
    logic ra;
    logic fa;
    logic rb;
    logic fb;
    logic up;
    logic dn;
    ra = a & ~pa;
    fa = ~a & pa;
    rb = b & ~pb;
    fb = ~b & pb;
    case (mode)
      qcpm_pkg::QCPM_SIMPLE: begin
        // a pulse on one phase with the other low counts up for A, down for B
        up = ra & ~b;
        dn = rb & ~a;
      end
      qcpm_pkg::QCPM_X1: begin
        // jiggle at the A edge cancels itself
        up = ra & ~b;
        dn = fa & ~b;
      end
      qcpm_pkg::QCPM_X2: begin
        up = (ra & ~b) | (fa & b);
        dn = (ra & b) | (fa & ~b);
      end
      default: begin
        up = (ra & ~b) | (fa & b) | (rb & a) | (fb & ~a);
        dn = (ra & b) | (fa & ~b) | (rb & ~a) | (fb & a);
      end
    endcase
    if (up && !dn) begin
      quad_step = 2'h1;
    end else if (dn && !up) begin
      quad_step = 2'h3;
    end else begin
      quad_step = 2'h0;
    end
  endfunction

  function automatic logic [31:0] sat_inc(logic [31:0] v);
    sat_inc = (v == qcpm_pkg::MEAS_MAX) ? v : v + 32'h1;
  endfunction

  function automatic logic [7:0] reg_addr(logic [7:0] base, int idx);
    reg_addr = base + {idx[5:0], 2'h0};
  endfunction

  // ==========================================================================
  // configuration
  qcpm_pkg::qcpm_mode_t mode [qcpm_pkg::NUM_CTR];
  qcpm_pkg::qcpm_mode_t next_mode [qcpm_pkg::NUM_CTR];
  logic [1:0] ctr_en;
  logic [1:0] next_ctr_en;
  logic [3:0] pm_en;
  logic [3:0] next_pm_en;
  logic res_tenth;
  logic next_res_tenth;
  logic [3:0] pm_act;

  always_comb begin
    next_mode = mode;
    next_ctr_en = ctr_en;
    next_pm_en = pm_en;
    next_res_tenth = res_tenth;
    if (wr) begin
      case (addr)
        qcpm_pkg::ADDR_MODE: begin
          // other channel numbers and mode codes above 3 are ignored
          if (wdata[7:2] == 6'h00) begin
            if (wdata[qcpm_pkg::MODE_CH_POS +: 8] == qcpm_pkg::CH1_SEL) begin
              next_mode[0] = qcpm_pkg::qcpm_mode_t'(wdata[1:0]);
            end else if (wdata[qcpm_pkg::MODE_CH_POS +: 8] == qcpm_pkg::CH2_SEL) begin
              next_mode[1] = qcpm_pkg::qcpm_mode_t'(wdata[1:0]);
            end
          end
        end
        qcpm_pkg::ADDR_LEGACY: begin
          for (int i = 0; i < qcpm_pkg::NUM_CTR; i++) begin
            next_mode[i] = wdata[i] ? qcpm_pkg::QCPM_X1 : qcpm_pkg::QCPM_SIMPLE;
          end
        end
        qcpm_pkg::ADDR_RES: begin
          next_res_tenth = wdata[0];
        end
        qcpm_pkg::ADDR_CTR_EN: begin
          next_ctr_en = wdata[1:0];
        end
        qcpm_pkg::ADDR_PM_EN: begin
          next_pm_en = wdata[3:0];
          for (int i = 0; i < qcpm_pkg::NUM_CTR; i++) begin
            if (wdata[2 * i] || wdata[2 * i + 1]) begin
              next_ctr_en[i] = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode[0] <= qcpm_pkg::QCPM_SIMPLE;
      mode[1] <= qcpm_pkg::QCPM_SIMPLE;
      ctr_en <= qcpm_pkg::CTR_EN_RST;
      pm_en <= qcpm_pkg::PM_EN_RST;
      res_tenth <= qcpm_pkg::RES_TENTH_RST;
    end else begin
      mode <= next_mode;
      ctr_en <= next_ctr_en;
      pm_en <= next_pm_en;
      res_tenth <= next_res_tenth;
    end
  end

  // a defined counter also meters its pair; metering alone leaves counters off
  assign pm_act = pm_en | {ctr_en[1], ctr_en[1], ctr_en[0], ctr_en[0]};

  // ==========================================================================
  // quadrature counters
  logic [3:0] in_prev;
  logic [CNT_W-1:0] cnt [qcpm_pkg::NUM_CTR];
  logic [CNT_W-1:0] next_cnt [qcpm_pkg::NUM_CTR];

  always_comb begin
    logic [1:0] step;
    step = 2'h0;
    for (int i = 0; i < qcpm_pkg::NUM_CTR; i++) begin
      next_cnt[i] = cnt[i];
      step = quad_step(mode[i], in_prev[2 * i], in_prev[2 * i + 1],
                       in_sig[2 * i], in_sig[2 * i + 1]);
      if (ctr_en[i]) begin
        if (step == 2'h1) begin
          next_cnt[i] = cnt[i] + CNT_W'(1);
        end else if (step == 2'h3) begin
          next_cnt[i] = cnt[i] - CNT_W'(1);
        end
      end
      // software preset takes priority over a count
      if (wr && addr == reg_addr(qcpm_pkg::ADDR_CTR0, i)) begin
        next_cnt[i] = wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt[0] <= '0;
      cnt[1] <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ==========================================================================
  // timebase tick, one microsecond or one tenth
  logic [qcpm_pkg::TICK_W-1:0] tick_cnt;
  logic [qcpm_pkg::TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;

  always_comb begin
    logic [qcpm_pkg::TICK_W-1:0] last;
    last = res_tenth ? qcpm_pkg::TICK_W'(qcpm_pkg::TICK_TENTH_CYC - 1)
                     : qcpm_pkg::TICK_W'(qcpm_pkg::TICK_US_CYC - 1);
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + qcpm_pkg::TICK_W'(1);
    if (tick_cnt >= last) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // ==========================================================================
  // pulse meters
  logic [3:0] next_in_prev;
  logic [31:0] hi_cnt [qcpm_pkg::NUM_MEAS];
  logic [31:0] next_hi_cnt [qcpm_pkg::NUM_MEAS];
  logic [31:0] per_cnt [qcpm_pkg::NUM_MEAS];
  logic [31:0] next_per_cnt [qcpm_pkg::NUM_MEAS];
  logic [31:0] width [qcpm_pkg::NUM_MEAS];
  logic [31:0] next_width [qcpm_pkg::NUM_MEAS];
  logic [31:0] period [qcpm_pkg::NUM_MEAS];
  logic [31:0] next_period [qcpm_pkg::NUM_MEAS];
  logic [3:0] seen;
  logic [3:0] next_seen;
  logic [3:0] req;
  logic [3:0] next_req;
  logic div_start;
  logic [1:0] div_pick;

  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    next_in_prev = in_sig;
    next_seen = seen;
    next_req = req;
    if (div_start) begin
      next_req[div_pick] = 1'b0;
    end
    for (int i = 0; i < qcpm_pkg::NUM_MEAS; i++) begin
      rise = in_sig[i] & ~in_prev[i];
      fall = ~in_sig[i] & in_prev[i];
      next_width[i] = width[i];
      next_period[i] = period[i];
      next_per_cnt[i] = rise ? 32'h0 : (tick ? sat_inc(per_cnt[i]) : per_cnt[i]);
      next_hi_cnt[i] = rise ? 32'h0 : ((tick && in_sig[i]) ? sat_inc(hi_cnt[i]) : hi_cnt[i]);
      if (pm_act[i]) begin
        if (rise) begin
          next_seen[i] = 1'b1;
          if (seen[i]) begin
            next_period[i] = per_cnt[i];
            next_req[i] = 1'b1;
          end
        end
        if (fall && seen[i]) begin
          next_width[i] = hi_cnt[i];
        end
        // a stalled input saturates the period so the frequency reads zero
        if (per_cnt[i] == qcpm_pkg::MEAS_MAX && period[i] != qcpm_pkg::MEAS_MAX) begin
          next_period[i] = qcpm_pkg::MEAS_MAX;
          next_req[i] = 1'b1;
        end
      end else begin
        next_seen[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_prev <= 4'h0;
      seen <= 4'h0;
      req <= 4'h0;
      for (int i = 0; i < qcpm_pkg::NUM_MEAS; i++) begin
        hi_cnt[i] <= 32'h0;
        per_cnt[i] <= 32'h0;
        width[i] <= 32'h0;
        period[i] <= 32'h0;
      end
    end else begin
      in_prev <= next_in_prev;
      seen <= next_seen;
      req <= next_req;
      hi_cnt <= next_hi_cnt;
      per_cnt <= next_per_cnt;
      width <= next_width;
      period <= next_period;
    end
  end

  // ==========================================================================
  // shared divider: frequency = ticks per second / period
  qcpm_pkg::qcpm_div_state_t div_state;
  qcpm_pkg::qcpm_div_state_t next_div_state;
  logic [1:0] div_ch;
  logic [1:0] next_div_ch;
  logic [31:0] div_num;
  logic [31:0] next_div_num;
  logic [31:0] div_den;
  logic [31:0] next_div_den;
  logic [32:0] div_rem;
  logic [32:0] next_div_rem;
  logic [4:0] div_bit;
  logic [4:0] next_div_bit;
  logic [31:0] freq [qcpm_pkg::NUM_MEAS];
  logic [31:0] next_freq [qcpm_pkg::NUM_MEAS];

  always_comb begin
    logic [32:0] shifted;
    shifted = '0;
    div_pick = 2'h0;
    for (int i = qcpm_pkg::NUM_MEAS - 1; i >= 0; i--) begin
      if (req[i]) begin
        div_pick = 2'(i);
      end
    end
    div_start = (div_state == qcpm_pkg::QCPM_DIV_IDLE) && (req != 4'h0);
    next_div_state = div_state;
    next_div_ch = div_ch;
    next_div_num = div_num;
    next_div_den = div_den;
    next_div_rem = div_rem;
    next_div_bit = div_bit;
    next_freq = freq;
    case (div_state)
      qcpm_pkg::QCPM_DIV_IDLE: begin
        if (div_start) begin
          next_div_ch = div_pick;
          next_div_num = res_tenth ? qcpm_pkg::FREQ_NUM_TENTH : qcpm_pkg::FREQ_NUM_US;
          next_div_den = period[div_pick];
          next_div_rem = '0;
          next_div_bit = '0;
          next_div_state = qcpm_pkg::QCPM_DIV_RUN;
        end
      end
      qcpm_pkg::QCPM_DIV_RUN: begin
        shifted = {div_rem[31:0], div_num[31]};
        if (shifted >= {1'b0, div_den}) begin
          next_div_rem = shifted - {1'b0, div_den};
          next_div_num = {div_num[30:0], 1'b1};
        end else begin
          next_div_rem = shifted;
          next_div_num = {div_num[30:0], 1'b0};
        end
        next_div_bit = div_bit + 5'h1;
        if (div_bit == qcpm_pkg::DIV_LAST_BIT) begin
          next_freq[div_ch] = (div_den == 32'h0) ? 32'h0 : next_div_num;
          next_div_state = qcpm_pkg::QCPM_DIV_IDLE;
        end
      end
      default: begin
        next_div_state = qcpm_pkg::QCPM_DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_state <= qcpm_pkg::QCPM_DIV_IDLE;
      div_ch <= 2'h0;
      div_num <= 32'h0;
      div_den <= 32'h0;
      div_rem <= 33'h0;
      div_bit <= 5'h0;
      for (int i = 0; i < qcpm_pkg::NUM_MEAS; i++) begin
        freq[i] <= 32'h0;
      end
    end else begin
      div_state <= next_div_state;
      div_ch <= next_div_ch;
      div_num <= next_div_num;
      div_den <= next_div_den;
      div_rem <= next_div_rem;
      div_bit <= next_div_bit;
      freq <= next_freq;
    end
  end

  // ==========================================================================
  // register read port
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (rd) begin
      case (addr)
        qcpm_pkg::ADDR_MODE: begin
          next_rdata[1:0] = mode[0];
          next_rdata[qcpm_pkg::MODE_RD_CH2_POS +: 2] = mode[1];
        end
        qcpm_pkg::ADDR_RES: next_rdata[0] = res_tenth;
        qcpm_pkg::ADDR_CTR_EN: next_rdata[1:0] = ctr_en;
        qcpm_pkg::ADDR_PM_EN: next_rdata[3:0] = pm_act;
        default: begin
        end
      endcase
      for (int i = 0; i < qcpm_pkg::NUM_CTR; i++) begin
        if (addr == reg_addr(qcpm_pkg::ADDR_CTR0, i)) begin
          next_rdata = 32'(signed'(cnt[i]));
        end
      end
      for (int i = 0; i < qcpm_pkg::NUM_MEAS; i++) begin
        if (addr == reg_addr(qcpm_pkg::ADDR_WIDTH0, i)) begin
          next_rdata = width[i];
        end
        if (addr == reg_addr(qcpm_pkg::ADDR_PERIOD0, i)) begin
          next_rdata = period[i];
        end
        if (addr == reg_addr(qcpm_pkg::ADDR_FREQ0, i)) begin
          next_rdata = freq[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

/* design/qcpm_pkg.sv */
// constants, register map and types of the quadrature counter and pulse meter
package qcpm_pkg;

  // ==========================================================================
  // timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US_NS = 1000;
  localparam int TICK_TENTH_NS = 100;
  localparam int TICK_US_CYC = (TICK_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_TENTH_CYC = (TICK_TENTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;

  // ==========================================================================
  // measurement
  localparam int MEAS_W = 32;
  localparam int NUM_MEAS = 4;
  localparam int NUM_CTR = 2;
  localparam logic [31:0] FREQ_NUM_US = 32'h000f4240;
  localparam logic [31:0] FREQ_NUM_TENTH = 32'h00989680;
  localparam logic [31:0] MEAS_MAX = 32'hffffffff;
  localparam logic [4:0] DIV_LAST_BIT = 5'h1f;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_LEGACY = 8'h04;
  localparam logic [7:0] ADDR_RES = 8'h08;
  localparam logic [7:0] ADDR_CTR_EN = 8'h0c;
  localparam logic [7:0] ADDR_PM_EN = 8'h10;
  localparam logic [7:0] ADDR_CTR0 = 8'h20;
  localparam logic [7:0] ADDR_WIDTH0 = 8'h40;
  localparam logic [7:0] ADDR_PERIOD0 = 8'h50;
  localparam logic [7:0] ADDR_FREQ0 = 8'h60;

  // mode word fields
  localparam logic [7:0] CH1_SEL = 8'h01;
  localparam logic [7:0] CH2_SEL = 8'h02;
  localparam int MODE_CH_POS = 8;
  localparam int MODE_RD_CH2_POS = 8;

  // reset values
  localparam logic RES_TENTH_RST = 1'b0;
  localparam logic [1:0] CTR_EN_RST = 2'h0;
  localparam logic [3:0] PM_EN_RST = 4'h0;

  typedef enum logic [1:0] {
    QCPM_SIMPLE,
    QCPM_X1,
    QCPM_X2,
    QCPM_X4
  } qcpm_mode_t;

  typedef enum logic {
    QCPM_DIV_IDLE,
    QCPM_DIV_RUN
  } qcpm_div_state_t;

endpackage

/* dv/qcpm_props.sv */
// concurrent checks on the register port of the quadrature counter and pulse meter
`timescale 1ns/1ns
module qcpm_props #(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] in_sig,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero after a cycle without read");
  unmapped_read_a: assert property (rd && addr[7] |=> rdata == 32'h0)
    else $error("unmapped read returned data");
  ctr_en_pm_a: assert property (wr && addr == qcpm_pkg::ADDR_CTR_EN && wdata[0]
    ##1 rd && addr == qcpm_pkg::ADDR_PM_EN |=> rdata[1:0] == 2'h3)
    else $error("counter enable did not enable its meters");
  pm_clears_ctr_a: assert property (wr && addr == qcpm_pkg::ADDR_PM_EN && wdata[0]
    ##1 rd && addr == qcpm_pkg::ADDR_CTR_EN |=> !rdata[0])
    else $error("meter enable left counter enabled");
  mode_write_a: assert property (wr && addr == qcpm_pkg::ADDR_MODE &&
    wdata[15:8] == 8'h01 && wdata[7:2] == 6'h0 ##1 rd && addr == qcpm_pkg::ADDR_MODE
    |=> rdata[1:0] == $past(wdata[1:0], 2))
    else $error("mode word not taken");
  mode_refuse_a: assert property (rd && addr == qcpm_pkg::ADDR_MODE ##1 wr &&
    addr == qcpm_pkg::ADDR_MODE && wdata[15:8] != 8'h01 && wdata[15:8] != 8'h02
    ##1 rd && addr == qcpm_pkg::ADDR_MODE |=> rdata == $past(rdata, 2))
    else $error("mode word with bad channel changed modes");
  legacy_mode_a: assert property (wr && addr == qcpm_pkg::ADDR_LEGACY && wdata[0]
    ##1 rd && addr == qcpm_pkg::ADDR_MODE |=> rdata[1:0] == 2'h1)
    else $error("legacy select not reflected in mode");
  res_read_a: assert property (wr && addr == qcpm_pkg::ADDR_RES
    ##1 rd && addr == qcpm_pkg::ADDR_RES |=> rdata[0] == $past(wdata[0], 2))
    else $error("resolution bit not taken");

  ch2_mode_c: cover property (wr && addr == qcpm_pkg::ADDR_MODE && wdata[15:8] == 8'h02);
  pm_clear_c: cover property (wr && addr == qcpm_pkg::ADDR_PM_EN && wdata[0]);
  freq_read_c: cover property (rd && addr == qcpm_pkg::ADDR_FREQ0 ##1 rdata != 32'h0);
endmodule

bind qcpm_top qcpm_props #(.CNT_W(CNT_W)) props_u (.clk(clk), .rst(rst), .in_sig(in_sig),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

/* dv/qcpm_enc_model.sv */
// two-channel quadrature encoder model, one phase step per step pulse
`timescale 1ns/1ns
module qcpm_enc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] step,
  input wire logic [1:0] up,
  input wire logic [1:0] single,
  output logic [3:0] in_sig
);
  // ==========================================================================
  // phase state
  logic [3:0] next_in_sig;
  always_comb begin
    next_in_sig = in_sig;
    for (int c = 0; c < 2; c++) begin
      if (step[c] && single[c]) begin
        // single phase: pulses on a for up, on b for down, other phase off
        next_in_sig[2 * c + (up[c] ? 0 : 1)] = ~in_sig[2 * c + (up[c] ? 0 : 1)];
      end else if (step[c]) begin
        // up: a leads b by a quarter cycle; down: a lags
        next_in_sig[2 * c] = up[c] ? ~in_sig[2 * c + 1] : in_sig[2 * c + 1];
        next_in_sig[2 * c + 1] = up[c] ? in_sig[2 * c] : ~in_sig[2 * c];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      in_sig <= 4'h0;
    end else begin
      in_sig <= next_in_sig;
    end
  end
endmodule

/* dv/tb_top.sv */
// self-checking bench for the quadrature counter and pulse meter
`timescale 1ns/1ns
module tb_top;
  typedef struct {int ch; logic [1:0] mode; logic up; logic single; int n; logic [31:0] exp;}
    qcpm_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] in_sig;
  logic [1:0] step = 2'h0;
  logic [1:0] up = 2'h0;
  logic [1:0] single = 2'h0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [7:0] rst_addr [10];
  qcpm_row_t rows [12];

  qcpm_top dut_u (.clk(clk), .rst(rst), .in_sig(in_sig), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  qcpm_enc_model enc_u (.clk(clk), .rst(rst), .step(step), .up(up), .single(single),
    .in_sig(in_sig));

  // ==========================================================================
  // clock and hang limit
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // tasks
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    check_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("mismatch %s expected %0d to %0d seen %0d", name, lo, hi, g);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, 1'b1, a, 32'h0);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // write immediately followed by a read
  task automatic wr_rd(input logic [7:0] wa, input logic [31:0] wd, input logic [7:0] ra,
    output logic [31:0] d);
    bus(1'b1, 1'b0, wa, wd);
    rd_reg(ra, d);
  endtask
  task automatic run_steps(input int ch, input logic u, input logic s, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      step[ch] <= 1'b1;
      up[ch] <= u;
      single[ch] <= s;
      @(posedge clk);
      step <= 2'h0;
      repeat (gap - 2) @(posedge clk);
    end
  endtask
  // inputs run at 10 us period, 5 us high
  task automatic meter_chk(input logic res);
    logic [31:0] num;
    int p;
    num = res ? qcpm_pkg::FREQ_NUM_TENTH : qcpm_pkg::FREQ_NUM_US;
    p = res ? 100 : 10;
    for (int n = 0; n < 2; n++) begin
      rd_reg(qcpm_pkg::ADDR_PERIOD0 + 8'(4 * n), v);
      chk_rng("period", 32'(p - 1), 32'(p + 1), v);
      rd_reg(qcpm_pkg::ADDR_WIDTH0 + 8'(4 * n), v);
      chk_rng("width", 32'(p / 2 - 1), 32'(p / 2 + 1), v);
      rd_reg(qcpm_pkg::ADDR_FREQ0 + 8'(4 * n), v);
      chk_rng("frequency", num / 32'(p + 1), num / 32'(p - 1), v);
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rows = '{'{0, 2'h0, 1'b1, 1'b0, 8, 32'h2}, '{0, 2'h0, 1'b0, 1'b0, 8, 32'hfffffffe},
      '{0, 2'h1, 1'b1, 1'b0, 8, 32'h2}, '{0, 2'h1, 1'b0, 1'b0, 8, 32'hfffffffe},
      '{0, 2'h2, 1'b1, 1'b0, 8, 32'h4}, '{0, 2'h2, 1'b0, 1'b0, 8, 32'hfffffffc},
      '{0, 2'h3, 1'b1, 1'b0, 8, 32'h8}, '{0, 2'h3, 1'b0, 1'b0, 8, 32'hfffffff8},
      '{1, 2'h3, 1'b1, 1'b0, 8, 32'h8}, '{1, 2'h2, 1'b0, 1'b0, 8, 32'hfffffffc},
      '{0, 2'h0, 1'b1, 1'b1, 6, 32'h3}, '{0, 2'h0, 1'b0, 1'b1, 6, 32'hfffffffd}};
    rst_addr = '{qcpm_pkg::ADDR_MODE, qcpm_pkg::ADDR_RES, qcpm_pkg::ADDR_CTR_EN,
      qcpm_pkg::ADDR_PM_EN, qcpm_pkg::ADDR_CTR0, qcpm_pkg::ADDR_CTR0 + 8'h4,
      qcpm_pkg::ADDR_WIDTH0, qcpm_pkg::ADDR_PERIOD0, qcpm_pkg::ADDR_FREQ0, 8'h80};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr_rd(qcpm_pkg::ADDR_MODE, {16'h0, 8'(rows[i].ch + 1), 6'h0, rows[i].mode},
        qcpm_pkg::ADDR_MODE, v);
      chk("mode", {30'h0, rows[i].mode}, (v >> (8 * rows[i].ch)) & 32'h3);
      wr_reg(qcpm_pkg::ADDR_CTR0 + 8'(4 * rows[i].ch), 32'h0);
      wr_reg(qcpm_pkg::ADDR_CTR_EN, 32'h3);
      run_steps(rows[i].ch, rows[i].up, rows[i].single, rows[i].n, 4);
      rd_reg(qcpm_pkg::ADDR_CTR0 + 8'(4 * rows[i].ch), v);
      chk("count", rows[i].exp, v);
    end
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_addr[i]) begin
      rd_reg(rst_addr[i], v);
      chk("reset value", 32'h0, v);
    end
    wr_reg(8'h84, 32'h5a5a5a5a);
    rd_reg(8'h84, v);
    chk("unmapped", 32'h0, v);
    wr_rd(qcpm_pkg::ADDR_CTR_EN, 32'h1, qcpm_pkg::ADDR_PM_EN, v);
    chk("derived meter enable", 32'h3, v);
    wr_rd(qcpm_pkg::ADDR_LEGACY, 32'h1, qcpm_pkg::ADDR_MODE, v);
    chk("legacy mode", 32'h1, v);
    wr_rd(qcpm_pkg::ADDR_MODE, 32'h0103, qcpm_pkg::ADDR_MODE, v);
    chk("mode override", 32'h3, v);
    bus(1'b0, 1'b1, qcpm_pkg::ADDR_MODE, 32'h0);
    wr_rd(qcpm_pkg::ADDR_MODE, 32'h0303, qcpm_pkg::ADDR_MODE, v);
    chk("bad channel", 32'h3, v);
    wr_rd(qcpm_pkg::ADDR_MODE, 32'h0104, qcpm_pkg::ADDR_MODE, v);
    chk("bad mode", 32'h3, v);
    // meters enabled once through the counter, then two timed runs
    run_steps(0, 1'b1, 1'b0, 16, 250);
    repeat (300) @(posedge clk);
    meter_chk(1'b0);
    rd_reg(qcpm_pkg::ADDR_CTR0, v);
    chk("shared count", 32'h10, v);
    wr_rd(qcpm_pkg::ADDR_RES, 32'h1, qcpm_pkg::ADDR_RES, v);
    chk("resolution", 32'h1, v);
    run_steps(0, 1'b1, 1'b0, 16, 250);
    repeat (300) @(posedge clk);
    meter_chk(1'b1);
    rd_reg(qcpm_pkg::ADDR_CTR0, v);
    chk("shared count", 32'h20, v);
    wr_rd(qcpm_pkg::ADDR_PM_EN, 32'h1, qcpm_pkg::ADDR_CTR_EN, v);
    chk("counter disabled", 32'h0, v);
    run_steps(0, 1'b1, 1'b0, 4, 4);
    rd_reg(qcpm_pkg::ADDR_CTR0, v);
    chk("count held", 32'h20, v);
    complete_run();
  end
endmodule
